// *** mtcc_consts.svh ***
// Register offsets, field positions, codes and reset values of the motor timer.
`ifndef MTCC_CONSTS_SVH
`define MTCC_CONSTS_SVH

`define MTCC_AW            32
`define MTCC_DW            16
`define MTCC_A_START       32'hFFFF8240
`define MTCC_A_C0_CTRL     32'hFFFF8260
`define MTCC_A_C0_MODE     32'hFFFF8261
`define MTCC_A_C0_IOH      32'hFFFF8262
`define MTCC_A_C0_IOL      32'hFFFF8263
`define MTCC_A_C0_IEN      32'hFFFF8264
`define MTCC_A_C0_STAT     32'hFFFF8265
`define MTCC_A_C0_CNT      32'hFFFF8266
`define MTCC_A_C0_GA       32'hFFFF8268
`define MTCC_A_C0_GB       32'hFFFF826A
`define MTCC_A_C0_GC       32'hFFFF826C
`define MTCC_A_C0_GD       32'hFFFF826E
`define MTCC_A_C1_CTRL     32'hFFFF8280
`define MTCC_A_C1_MODE     32'hFFFF8281
`define MTCC_A_C1_IEN      32'hFFFF8284
`define MTCC_A_C1_STAT     32'hFFFF8285
`define MTCC_A_C1_CNT      32'hFFFF8286
`define MTCC_A_C1_GA       32'hFFFF8288

`define MTCC_CCLR_HI       7
`define MTCC_CCLR_LO       5
`define MTCC_TPSC_HI       2
`define MTCC_TPSC_LO       0
`define MTCC_MD_HI         3
`define MTCC_MD_LO         0
`define MTCC_IOLO_HI       3
`define MTCC_IOLO_LO       0
`define MTCC_IOHI_HI       7
`define MTCC_IOHI_LO       4

`define MTCC_CCLR_A        3'h1
`define MTCC_CCLR_B        3'h2
`define MTCC_CCLR_C        3'h5
`define MTCC_CCLR_D        3'h6
`define MTCC_TPSC_1        3'h0
`define MTCC_TPSC_4        3'h1
`define MTCC_TPSC_16       3'h2
`define MTCC_TPSC_64       3'h3
`define MTCC_PRE_M1        6'h00
`define MTCC_PRE_M4        6'h03
`define MTCC_PRE_M16       6'h0F
`define MTCC_PRE_M64       6'h3F
`define MTCC_PRE_W         6
`define MTCC_MD_NORMAL     4'h0
`define MTCC_IO_COMPARE    4'h0
`define MTCC_IO_RISE       4'h8
`define MTCC_IO_FALL       4'h9
`define MTCC_GR_RST        16'hFFFF
`define MTCC_NCAP          3
`define MTCC_IDX_D         3

`endif

// *** mtcc_pkg.sv ***
// Types shared by the motor timer capture and compare modules.
`include "mtcc_consts.svh"
package mtcc_pkg;

    typedef logic [`MTCC_AW-1:0] mtcc_addr_type;
    typedef logic [`MTCC_DW-1:0] mtcc_data_type;

    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
        logic cap;
    } mtcc_cap_state_type;

    typedef struct packed {
        logic [`MTCC_PRE_W-1:0] pre;
        logic [1:0]             start;
        logic [7:0]             c0_ctrl;
        logic [7:0]             c0_mode;
        logic [7:0]             c0_ioh;
        logic [7:0]             c0_iol;
        logic [3:0]             c0_ien;
        logic [3:0]             c0_stat;
        logic [15:0]            c0_cnt;
        logic [3:0][15:0]       c0_gr;
        logic [7:0]             c1_ctrl;
        logic [7:0]             c1_mode;
        logic                   c1_ien;
        logic                   c1_stat;
        logic [15:0]            c1_cnt;
        logic [15:0]            c1_ga;
        logic [15:0]            rdata;
    } mtcc_state_type;

endpackage

// *** mtcc_capture.sv ***
// Pin synchroniser and selectable edge detector for one capture input.
`timescale 1ns/100ps
`include "mtcc_consts.svh"
module mtcc_capture (
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic       pin_i,
    input  wire logic [3:0] sel_i,
    output logic            cap_o
);
    import mtcc_pkg::*;

    mtcc_cap_state_type st_r;
    mtcc_cap_state_type st_nxt;

    // Only the second stage and its delayed copy feed the edge logic, so a metastable first stage never reaches it.
    always_comb begin
        st_nxt      = st_r;
        st_nxt.s1   = pin_i;
        st_nxt.s2   = st_r.s1;
        st_nxt.prev = st_r.s2;
        st_nxt.cap  = ((sel_i == `MTCC_IO_RISE) && st_r.s2 && !st_r.prev) ||
                      ((sel_i == `MTCC_IO_FALL) && !st_r.s2 && st_r.prev);
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cap_o = st_r.cap;

endmodule

// *** mtcc_top.sv ***
// Two motor timer channels: channel 0 with three pin captures and compare D, channel 1 with compare A.
// Summary of operation
// - Channel 0 control selects compare D clearing and a count clock of clock/16.
// - Channel 1 control selects compare A as the channel 1 counter clear.
// - Channel 1 counter advances on clock/16 under its documented control setting.
// - Mode value with low nibble zero gives normal counting, no PWM or phase count.
// - Enable bits 0 to 3 pass flags A to D onto the interrupt; zero blocks.
// - Channel 0 compares general D with counter each count and sets flag D.
// - Channel 1 compares general A with counter each count and sets flag A.
// - High I/O field bits 0-3: 1000 captures A on rise, 1001 on fall.
// - High I/O field bits 4-7: 1000 captures B on rise, 1001 on fall.
// - Low I/O field bits 0-3: 1000 captures C on rise, 1001 on fall.
// - Low I/O field bits 4-7 at 0000 makes general D an output compare.
`timescale 1ns/100ps
`include "mtcc_consts.svh"
module mtcc_top (
    input  wire logic                   mclk_i,
    input  wire logic                   arst_n_i,
    input  wire mtcc_pkg::mtcc_addr_type addr_i,
    input  wire mtcc_pkg::mtcc_data_type wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output mtcc_pkg::mtcc_data_type     rdata_o,
    input  wire logic                   capture_input_a_i,
    input  wire logic                   capture_input_b_i,
    input  wire logic                   capture_input_c_i,
    output logic                        irq_o
);
    import mtcc_pkg::*;

    logic [1:0]             rst_sync_r;
    logic                   rst_n;
    logic [`MTCC_NCAP-1:0]  pins;
    logic [`MTCC_NCAP-1:0]  cap;
    logic [`MTCC_NCAP-1:0][3:0] cap_sel;
    mtcc_state_type         st_r;
    mtcc_state_type         st_nxt;

    localparam mtcc_state_type ST_RST = '{
        c0_gr   : {4{`MTCC_GR_RST}},
        c1_ga   : `MTCC_GR_RST,
        default : '0
    };

    // Reset is asserted at once but released only after two clean clock edges.
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_r[1];

    assign pins    = {capture_input_c_i, capture_input_b_i, capture_input_a_i};
    assign cap_sel = {st_r.c0_iol[`MTCC_IOLO_HI:`MTCC_IOLO_LO],
                      st_r.c0_ioh[`MTCC_IOHI_HI:`MTCC_IOHI_LO],
                      st_r.c0_ioh[`MTCC_IOLO_HI:`MTCC_IOLO_LO]};

    generate
        for (genvar g = 0; g < `MTCC_NCAP; g++) begin : g_cap
            mtcc_capture u_cap (
                .mclk_i  (mclk_i),
                .rst_n_i (rst_n),
                .pin_i   (pins[g]),
                .sel_i   (cap_sel[g]),
                .cap_o   (cap[g])
            );
        end
    endgenerate

    // One shared prescaler; each channel picks its own divide ratio from it.
    function automatic logic tick_of(input logic [2:0] tpsc, input logic [`MTCC_PRE_W-1:0] pre);
        logic [`MTCC_PRE_W-1:0] m;
        m = `MTCC_PRE_M1;
        unique case (tpsc)
            `MTCC_TPSC_1: begin
                m = `MTCC_PRE_M1;
            end
            `MTCC_TPSC_4: begin
                m = `MTCC_PRE_M4;
            end
            `MTCC_TPSC_16: begin
                m = `MTCC_PRE_M16;
            end
            `MTCC_TPSC_64: begin
                m = `MTCC_PRE_M64;
            end
            default: begin
                return 1'b0;
            end
        endcase
        return (pre & m) == m;
    endfunction

    function automatic logic run_of(input logic start, input logic [7:0] mode);
        return start && (mode[`MTCC_MD_HI:`MTCC_MD_LO] == `MTCC_MD_NORMAL);
    endfunction

    logic       tick0;
    logic       tick1;
    logic [3:0] eq0;
    logic [3:0] set0;
    logic       set1;
    logic       clr0;
    logic       clr1;
    logic [2:0] cclr0;

    always_comb begin
        st_nxt       = st_r;
        st_nxt.rdata = '0;
        st_nxt.pre   = st_r.pre + `MTCC_PRE_W'(1);
        tick0 = run_of(st_r.start[0], st_r.c0_mode) &&
                tick_of(st_r.c0_ctrl[`MTCC_TPSC_HI:`MTCC_TPSC_LO], st_r.pre);
        tick1 = run_of(st_r.start[1], st_r.c1_mode) &&
                tick_of(st_r.c1_ctrl[`MTCC_TPSC_HI:`MTCC_TPSC_LO], st_r.pre);
        for (int i = 0; i < 4; i++) begin
            eq0[i] = (st_r.c0_cnt == st_r.c0_gr[i]);
        end
        set0 = 4'h0;
        for (int i = 0; i < `MTCC_NCAP; i++) begin
            if (tick0 && eq0[i] && (cap_sel[i] == `MTCC_IO_COMPARE)) begin
                set0[i] = 1'b1;
            end
        end
        if (tick0 && eq0[`MTCC_IDX_D] &&
            (st_r.c0_iol[`MTCC_IOHI_HI:`MTCC_IOHI_LO] == `MTCC_IO_COMPARE)) begin
            set0[`MTCC_IDX_D] = 1'b1;
        end
        set1  = tick1 && (st_r.c1_cnt == st_r.c1_ga);
        cclr0 = st_r.c0_ctrl[`MTCC_CCLR_HI:`MTCC_CCLR_LO];
        clr0  = ((cclr0 == `MTCC_CCLR_A) && eq0[0]) ||
                ((cclr0 == `MTCC_CCLR_B) && eq0[1]) ||
                ((cclr0 == `MTCC_CCLR_C) && eq0[2]) ||
                ((cclr0 == `MTCC_CCLR_D) && eq0[`MTCC_IDX_D]);
        clr1  = (st_r.c1_ctrl[`MTCC_CCLR_HI:`MTCC_CCLR_LO] == `MTCC_CCLR_A) &&
                (st_r.c1_cnt == st_r.c1_ga);
        if (tick0) begin
            st_nxt.c0_cnt = clr0 ? 16'h0000 : st_r.c0_cnt + 16'h0001;
        end
        if (tick1) begin
            st_nxt.c1_cnt = clr1 ? 16'h0000 : st_r.c1_cnt + 16'h0001;
        end
        if (wr_i) begin
            unique case (addr_i)
                `MTCC_A_START: begin
                    st_nxt.start = wdata_i[1:0];
                end
                `MTCC_A_C0_CTRL: begin
                    st_nxt.c0_ctrl = wdata_i[7:0];
                end
                `MTCC_A_C0_MODE: begin
                    st_nxt.c0_mode = wdata_i[7:0];
                end
                `MTCC_A_C0_IOH: begin
                    st_nxt.c0_ioh = wdata_i[7:0];
                end
                `MTCC_A_C0_IOL: begin
                    st_nxt.c0_iol = wdata_i[7:0];
                end
                `MTCC_A_C0_IEN: begin
                    st_nxt.c0_ien = wdata_i[3:0];
                end
                `MTCC_A_C0_STAT: begin
                    st_nxt.c0_stat = st_r.c0_stat & wdata_i[3:0];
                end
                `MTCC_A_C0_CNT: begin
                    st_nxt.c0_cnt = wdata_i;
                end
                `MTCC_A_C0_GA: begin
                    st_nxt.c0_gr[0] = wdata_i;
                end
                `MTCC_A_C0_GB: begin
                    st_nxt.c0_gr[1] = wdata_i;
                end
                `MTCC_A_C0_GC: begin
                    st_nxt.c0_gr[2] = wdata_i;
                end
                `MTCC_A_C0_GD: begin
                    st_nxt.c0_gr[`MTCC_IDX_D] = wdata_i;
                end
                `MTCC_A_C1_CTRL: begin
                    st_nxt.c1_ctrl = wdata_i[7:0];
                end
                `MTCC_A_C1_MODE: begin
                    st_nxt.c1_mode = wdata_i[7:0];
                end
                `MTCC_A_C1_IEN: begin
                    st_nxt.c1_ien = wdata_i[0];
                end
                `MTCC_A_C1_STAT: begin
                    st_nxt.c1_stat = st_r.c1_stat & wdata_i[0];
                end
                `MTCC_A_C1_CNT: begin
                    st_nxt.c1_cnt = wdata_i;
                end
                `MTCC_A_C1_GA: begin
                    st_nxt.c1_ga = wdata_i;
                end
                default: begin
                end
            endcase
        end
        // A capture overrides a software write to the same general register in that cycle.
        for (int i = 0; i < `MTCC_NCAP; i++) begin
            if (cap[i]) begin
                st_nxt.c0_gr[i] = st_r.c0_cnt;
                set0[i]         = 1'b1;
            end
        end
        // Hardware sets are applied last so they win over a clearing write.
        st_nxt.c0_stat = st_nxt.c0_stat | set0;
        st_nxt.c1_stat = st_nxt.c1_stat | set1;
        if (rd_i) begin
            unique case (addr_i)
                `MTCC_A_START: begin
                    st_nxt.rdata = {14'h0000, st_r.start};
                end
                `MTCC_A_C0_CTRL: begin
                    st_nxt.rdata = {8'h00, st_r.c0_ctrl};
                end
                `MTCC_A_C0_MODE: begin
                    st_nxt.rdata = {8'h00, st_r.c0_mode};
                end
                `MTCC_A_C0_IOH: begin
                    st_nxt.rdata = {8'h00, st_r.c0_ioh};
                end
                `MTCC_A_C0_IOL: begin
                    st_nxt.rdata = {8'h00, st_r.c0_iol};
                end
                `MTCC_A_C0_IEN: begin
                    st_nxt.rdata = {12'h000, st_r.c0_ien};
                end
                `MTCC_A_C0_STAT: begin
                    st_nxt.rdata = {12'h000, st_r.c0_stat};
                end
                `MTCC_A_C0_CNT: begin
                    st_nxt.rdata = st_r.c0_cnt;
                end
                `MTCC_A_C0_GA: begin
                    st_nxt.rdata = st_r.c0_gr[0];
                end
                `MTCC_A_C0_GB: begin
                    st_nxt.rdata = st_r.c0_gr[1];
                end
                `MTCC_A_C0_GC: begin
                    st_nxt.rdata = st_r.c0_gr[2];
                end
                `MTCC_A_C0_GD: begin
                    st_nxt.rdata = st_r.c0_gr[`MTCC_IDX_D];
                end
                `MTCC_A_C1_CTRL: begin
                    st_nxt.rdata = {8'h00, st_r.c1_ctrl};
                end
                `MTCC_A_C1_MODE: begin
                    st_nxt.rdata = {8'h00, st_r.c1_mode};
                end
                `MTCC_A_C1_IEN: begin
                    st_nxt.rdata = {15'h0000, st_r.c1_ien};
                end
                `MTCC_A_C1_STAT: begin
                    st_nxt.rdata = {15'h0000, st_r.c1_stat};
                end
                `MTCC_A_C1_CNT: begin
                    st_nxt.rdata = st_r.c1_cnt;
                end
                `MTCC_A_C1_GA: begin
                    st_nxt.rdata = st_r.c1_ga;
                end
                default: begin
                    st_nxt.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata_o = st_r.rdata;
    // The request is a level, so it falls only once every set flag is cleared or has its enable bit cleared.
    assign irq_o   = (|(st_r.c0_stat & st_r.c0_ien)) || (st_r.c1_stat && st_r.c1_ien);

endmodule

// *** mtcc_top_sva.sv ***
// Port-level checker for the motor timer capture and compare block.
`timescale 1ns/100ps
`include "mtcc_consts.svh"
module mtcc_top_sva (
    input wire logic                    mclk_i,
    input wire logic                    arst_n_i,
    input wire mtcc_pkg::mtcc_addr_type addr_i,
    input wire mtcc_pkg::mtcc_data_type wdata_i,
    input wire logic                    wr_i,
    input wire logic                    rd_i,
    input wire mtcc_pkg::mtcc_data_type rdata_o,
    input wire logic                    capture_input_a_i,
    input wire logic                    capture_input_b_i,
    input wire logic                    capture_input_c_i,
    input wire logic                    irq_o
);
    import mtcc_pkg::*;
    logic [7:0] ctl_r;
    logic [7:0] ioh_r;
    logic [7:0] iol_r;
    logic [3:0] en0_r;
    logic [1:0] run_r;
    logic       en1_r;
    // Shadows of the settings software wrote, so outputs can be tied to them.
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            {ctl_r, ioh_r, iol_r, en0_r, run_r, en1_r} <= '0;
        end else if (wr_i) begin
            case (addr_i)
                `MTCC_A_C0_CTRL: ctl_r <= wdata_i[7:0];
                `MTCC_A_C0_IOH:  ioh_r <= wdata_i[7:0];
                `MTCC_A_C0_IOL:  iol_r <= wdata_i[7:0];
                `MTCC_A_C0_IEN:  en0_r <= wdata_i[3:0];
                `MTCC_A_C1_IEN:  en1_r <= wdata_i[0];
                `MTCC_A_START:   run_r <= wdata_i[1:0];
                default:         en1_r <= en1_r;
            endcase
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    a_read_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data not zero outside a read");
    a_ctrl_read_back: assert property (rd_i && addr_i == `MTCC_A_C0_CTRL
        |=> rdata_o == {8'h00, $past(ctl_r)}) else $error("control read back wrong");
    a_unmapped_read: assert property (rd_i && addr_i == 32'hFFFF8290 |=> rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    a_irq_after_reset: assert property ($rose(arst_n_i) |-> !irq_o [*2])
        else $error("interrupt high after reset");
    a_irq_needs_enable: assert property (en0_r == 4'h0 && !en1_r |-> !irq_o)
        else $error("interrupt with all enables off");
    a_capture_a_rise: assert property ($rose(capture_input_a_i)
        && ioh_r[3:0] == `MTCC_IO_RISE && en0_r[0] |-> ##4 irq_o) else $error("no capture A");
    a_capture_b_fall: assert property ($fell(capture_input_b_i)
        && ioh_r[7:4] == `MTCC_IO_FALL && en0_r[1] |-> ##4 irq_o) else $error("no capture B");
    a_capture_c_rise: assert property ($rose(capture_input_c_i)
        && iol_r[3:0] == `MTCC_IO_RISE && en0_r[2] |-> ##4 irq_o) else $error("no capture C");
    a_flag_holds: assert property (irq_o && !wr_i |=> irq_o)
        else $error("interrupt dropped without a write");
    a_clear_drops: assert property (wr_i && addr_i == `MTCC_A_C0_STAT && wdata_i == 16'h0000
        && run_r == 2'h0 && !en1_r |=> !irq_o) else $error("status clear kept interrupt");
endmodule

// *** mtcc_pole_sensor.sv ***
// Rotor pole position sensor model driving the three capture pins.
`timescale 1ns/100ps
module mtcc_pole_sensor (
    input  wire logic       mclk_i,
    input  wire logic       step_i,
    input  wire logic [1:0] pin_sel_i,
    input  wire logic [3:0] lag_i,
    output logic [2:0]      pins_o
);
    // The sensor drives its outputs push-pull, so the pins always hold a level.
    logic [2:0] pins_r = 3'h0;
    logic [3:0] wait_r = 4'h0;
    logic [1:0] sel_r  = 2'h0;
    logic       busy_r = 1'b0;
    assign pins_o = pins_r;
    always_ff @(posedge mclk_i) begin
        if (step_i) begin
            sel_r <= pin_sel_i;
            wait_r <= lag_i;
            busy_r <= 1'b1;
        end else if (busy_r && wait_r != 4'h0) begin
            wait_r <= wait_r - 4'h1;
        end else if (busy_r) begin
            pins_r[sel_r] <= ~pins_r[sel_r];
            busy_r <= 1'b0;
        end
    end
endmodule

// *** motor_timer_capture_compare_test.sv ***
// Self-checking bench for the motor timer capture and compare block.
`timescale 1ns/100ps
`include "mtcc_consts.svh"
module motor_timer_capture_compare_test;
    import mtcc_pkg::*;
    logic          clk   = 1'b0;
    logic          rst_n = 1'b0;
    logic          wr    = 1'b0;
    logic          rd    = 1'b0;
    logic          step  = 1'b0;
    logic [1:0]    psel  = 2'h0;
    logic [3:0]    lag   = 4'h0;
    mtcc_addr_type addr  = '0;
    mtcc_data_type wdata = '0;
    mtcc_data_type rdata;
    logic [2:0]    pins;
    logic          irq;
    int            error_cnt = 0;
    int            samples_checked = 0;
    always #50 clk = ~clk;
    mtcc_top mtcc_top_i (.mclk_i(clk), .arst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .capture_input_a_i(pins[0]),
        .capture_input_b_i(pins[1]), .capture_input_c_i(pins[2]), .irq_o(irq));
    mtcc_pole_sensor mtcc_pole_sensor_i (.mclk_i(clk), .step_i(step), .pin_sel_i(psel),
        .lag_i(lag), .pins_o(pins));
    task automatic report_and_stop;
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input mtcc_data_type got, input mtcc_data_type exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input mtcc_addr_type a, input mtcc_data_type d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_val(input mtcc_addr_type a, output mtcc_data_type d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    task automatic rd_chk(input mtcc_addr_type a, input mtcc_data_type exp);
        mtcc_data_type d;
        rd_val(a, d);
        chk(d, exp);
    endtask
    task automatic wait_irq(output realtime t);
        int n;
        n = 0;
        @(negedge clk);
        while (irq !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        chk(16'(n == 2000), 16'h0000);
        t = $realtime;
    endtask
    // Flag to flag spacing is measured, since the free prescaler phase is unknown.
    task automatic period(input mtcc_addr_type st, input int cyc);
        realtime t0;
        realtime t1;
        int p;
        wr_reg(st, 16'h0000);
        wait_irq(t0);
        wr_reg(st, 16'h0000);
        wait_irq(t1);
        p = int'((t1 - t0) / 100.0);
        chk(p[15:0], cyc[15:0]);
    endtask
    task automatic t_reset;
        rd_chk(`MTCC_A_C0_CTRL, 16'h0000);
        rd_chk(`MTCC_A_C0_GD, `MTCC_GR_RST);
        rd_chk(`MTCC_A_C1_GA, `MTCC_GR_RST);
        wr_reg(32'hFFFF8290, 16'h00FF);
        rd_chk(32'hFFFF8290, 16'h0000);
    endtask
    task automatic t_ch1;
        mtcc_data_type v;
        wr_reg(`MTCC_A_C1_CTRL, 16'h0022);
        wr_reg(`MTCC_A_C1_MODE, 16'h00C0);
        wr_reg(`MTCC_A_C1_GA, 16'h0003);
        wr_reg(`MTCC_A_C1_IEN, 16'h0001);
        wr_reg(`MTCC_A_START, 16'h0002);
        period(`MTCC_A_C1_STAT, 64);
        wr_reg(`MTCC_A_C1_MODE, 16'h00C1);
        rd_val(`MTCC_A_C1_CNT, v);
        repeat (40) @(posedge clk);
        rd_chk(`MTCC_A_C1_CNT, v);
        wr_reg(`MTCC_A_START, 16'h0000);
        wr_reg(`MTCC_A_C1_IEN, 16'h0000);
        wr_reg(`MTCC_A_C1_STAT, 16'h0000);
    endtask
    task automatic t_ch0;
        wr_reg(`MTCC_A_C0_CTRL, 16'h00C2);
        rd_chk(`MTCC_A_C0_CTRL, 16'h00C2);
        wr_reg(`MTCC_A_C0_MODE, 16'h00C0);
        wr_reg(`MTCC_A_C0_IOL, 16'h0009);
        wr_reg(`MTCC_A_C0_GD, 16'h0004);
        wr_reg(`MTCC_A_C0_IEN, 16'h0008);
        wr_reg(`MTCC_A_START, 16'h0001);
        period(`MTCC_A_C0_STAT, 80);
        wr_reg(`MTCC_A_C0_IEN, 16'h0000);
        repeat (100) @(posedge clk);
        chk({15'h0000, irq}, 16'h0000);
        rd_chk(`MTCC_A_C0_STAT, 16'h0008);
        wr_reg(`MTCC_A_C0_IOL, 16'h0089);
        wr_reg(`MTCC_A_C0_STAT, 16'h0000);
        repeat (100) @(posedge clk);
        rd_chk(`MTCC_A_C0_STAT, 16'h0000);
        wr_reg(`MTCC_A_START, 16'h0000);
    endtask
    task automatic t_capture;
        mtcc_data_type v;
        logic hit;
        wr_reg(`MTCC_A_C0_IEN, 16'h0007);
        for (int p = 0; p < 2; p++) begin
            wr_reg(`MTCC_A_C0_IOH, p ? 16'h0099 : 16'h0088);
            wr_reg(`MTCC_A_C0_IOL, p ? 16'h0009 : 16'h0008);
            for (int i = 0; i < 3; i++) begin
                for (int e = 0; e < 2; e++) begin
                    v = 16'h1200 + 16'(p * 16 + i * 4 + e);
                    wr_reg(`MTCC_A_C0_CNT, v);
                    @(posedge clk);
                    psel <= 2'(i);
                    lag <= 4'(e * 9);
                    step <= 1'b1;
                    @(posedge clk);
                    step <= 1'b0;
                    repeat (24) @(posedge clk);
                    hit = (e == p);
                    chk({15'h0000, irq}, {15'h0000, hit});
                    rd_chk(`MTCC_A_C0_STAT, hit ? 16'(1 << i) : 16'h0000);
                    rd_chk(`MTCC_A_C0_STAT, hit ? 16'(1 << i) : 16'h0000);
                    if (hit) begin
                        rd_chk(`MTCC_A_C0_GA + 2 * i, v);
                    end
                    wr_reg(`MTCC_A_C0_STAT, 16'h0000);
                    @(negedge clk);
                    chk({15'h0000, irq}, 16'h0000);
                end
            end
        end
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset;
        t_ch1;
        t_ch0;
        t_capture;
        report_and_stop;
    end
    // The tests need about a thousand cycles; this limit leaves a wide margin.
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        report_and_stop;
    end
endmodule
bind mtcc_top mtcc_top_sva mtcc_top_sva_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .capture_input_a_i(capture_input_a_i), .capture_input_b_i(capture_input_b_i),
    .capture_input_c_i(capture_input_c_i), .irq_o(irq_o));
